/* hdl/dwell_timer.sv */
// dwell timer: base-interval prescaler followed by the dwell counter
`timescale 1ns/1ps
module dwell_timer
   import freq_scan_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   scan_if.timer     bus
);

   logic [MULT_W-1:0]  preCount;
   logic [DWELL_W-1:0] dwellCnt;
   logic [MULT_W-1:0]  next_preCount;
   logic [DWELL_W-1:0] next_dwellCnt;
   logic [MULT_W-1:0]  multValue;
   logic               unitTick;

   // ==========================================================
   // same multiplier for both dwell units
   always_comb begin
      case (bus.multSel)
         2'h0:    multValue = MULT_X1;
         2'h1:    multValue = MULT_X5;
         2'h2:    multValue = MULT_X100;
         2'h3:    multValue = MULT_X500;
         default: multValue = MULT_X1;
      endcase
   end

   assign unitTick = bus.dwellUnitClk ? 1'b1 : bus.cycleTick;

   // dwell end: unregistered so the step lands on the edge that closes the
   // interval, and free of restart so no loop runs through the sequencer
   assign bus.intervalDone = !bus.timerHold && unitTick && (preCount + 1'b1 == multValue)
                             && (dwellCnt + 1'b1 == bus.dwellCount);

   // prescaler and dwell counter
   always_comb begin
      next_preCount = preCount;
      next_dwellCnt = dwellCnt;
      if (bus.timerRestart) begin
         next_preCount = '0;
         next_dwellCnt = '0;
      end else if (!bus.timerHold && unitTick) begin
         if (preCount + 1'b1 == multValue) begin
            next_preCount = '0;
            if (dwellCnt + 1'b1 == bus.dwellCount) begin
               next_dwellCnt = '0;
            end else begin
               next_dwellCnt = dwellCnt + 1'b1;
            end
         end else begin
            next_preCount = preCount + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         preCount <= '0;
         dwellCnt <= '0;
      end else begin
         preCount <= next_preCount;
         dwellCnt <= next_dwellCnt;
      end
   end

endmodule

/* hdl/freq_scan_pkg.sv */
// constants, field layouts and state codes of the frequency-scan sequencer
package freq_scan_pkg;

   // ==========================================================
   // widths
   localparam int WORD_W  = 16;
   localparam int FREQ_W  = 24;
   localparam int STEP_W  = 23;
   localparam int COUNT_W = 12;
   localparam int DWELL_W = 11;
   localparam int MULT_W  = 9;
   localparam int DAC_W   = 10;
   localparam int BITCNT_W = 5;

   // ==========================================================
   // serial word decode: top nibble of each 16-bit word, top two bits for dwell
   localparam logic [3:0] OP_CONTROL    = 4'h0;
   localparam logic [3:0] OP_STEP_COUNT = 4'h1;
   localparam logic [3:0] OP_STEP_LOW   = 4'h2;
   localparam logic [3:0] OP_STEP_HIGH  = 4'h3;
   localparam logic [3:0] OP_START_LOW  = 4'hC;
   localparam logic [3:0] OP_START_HIGH = 4'hD;
   localparam logic [1:0] OP_DWELL      = 2'h1;   // only the top two bits

   // ==========================================================
   // field positions inside a word
   localparam int STEP_SOURCE_BIT = 5;
   localparam int DIRECTION_BIT   = 11;
   localparam int DWELL_UNIT_BIT  = 13;
   localparam int MULT_LSB        = 11;
   localparam int LOW_PART_W      = 12;
   localparam int STEP_HIGH_W     = 11;

   // ==========================================================
   // base-interval multipliers, in master-clock periods or output cycles
   localparam logic [MULT_W-1:0] MULT_X1   = 9'h001;
   localparam logic [MULT_W-1:0] MULT_X5   = 9'h005;
   localparam logic [MULT_W-1:0] MULT_X100 = 9'h064;
   localparam logic [MULT_W-1:0] MULT_X500 = 9'h1F4;

   // ==========================================================
   // reset values
   localparam logic [FREQ_W-1:0]  START_RESET   = 24'h000000;
   localparam logic [STEP_W-1:0]  STEP_RESET    = 23'h000000;
   localparam logic [COUNT_W-1:0] COUNT_RESET   = 12'h002;
   localparam logic [DWELL_W-1:0] DWELL_RESET   = 11'h002;
   localparam logic [1:0]         MULT_SEL_RESET = 2'h0;
   localparam logic [DAC_W-1:0]   MIDSCALE      = 10'h200;

   // ==========================================================
   // scan state machine
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_HOLD = 3'b100
   } scan_state_t;

endpackage

/* hdl/frequency_scan_sequencer.sv */
// frequency-scan sequencer: register decode, scan control and phase accumulator
//
// How it works
// - each step adds signed step to frequency
// - start, start plus step, plus two steps
// - 23-bit step loaded by two 16-bit words
// - nibble 0010 low bits, 0011 high plus sign
// - nibble 0001 loads 12-bit step count
// - step count unsigned, valid two to 4095
// - dwell bit 13 picks clocks or cycles
// - dwell count eleven bits, two to 2047
// - bits 12 and 11 pick 1,5,100,500
// - multiplier applies to both dwell units
// - scan lasts count intervals, then holds the last frequency
// - trigger rising edge starts scan from start
// - source bit zero: timer advances each step
// - source bit one: trigger edges advance steps
// - abort rising edge resets, output to midscale
// - sleep freezes accumulator and scan, then resumes
// - start frequency 24 bits in two words
`timescale 1ns/1ps
module frequency_scan_sequencer
   import freq_scan_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              serialClk,
   input  wire logic              frameSyncN,
   input  wire logic              serialData,
   input  wire logic              scanTrigger,
   input  wire logic              abortScan,
   input  wire logic              sleep,
   output logic [DAC_W-1:0]       dacCode,
   output logic [FREQ_W-1:0]      currentFrequency,
   output logic                   scanActive,
   output logic                   scanDone
);

   scan_if bus ();

   // ==========================================================
   // submodules
   serial_word_rx rx (
      .clk        (clk),
      .reset      (reset),
      .serialClk  (serialClk),
      .frameSyncN (frameSyncN),
      .serialData (serialData),
      .bus        (bus.rx)
   );

   dwell_timer timer (
      .clk   (clk),
      .reset (reset),
      .bus   (bus.timer)
   );

   // ==========================================================
   // pin synchronisers; third stage only for edge detection
   logic [2:0] trigSync;
   logic [2:0] abortSync;
   logic [1:0] sleepSync;

   // cleared to the idle low level of each pin, so reset fakes no edge
   always_ff @(posedge clk) begin
      if (reset) begin
         trigSync  <= 3'h0;
         abortSync <= 3'h0;
         sleepSync <= 2'h0;
      end else begin
         trigSync  <= {trigSync[1:0], scanTrigger};
         abortSync <= {abortSync[1:0], abortScan};
         sleepSync <= {sleepSync[0], sleep};
      end
   end

   logic trigRise;
   logic abortRise;
   logic asleep;

   // rising edges are taken from the settled stages only
   assign trigRise  = trigSync[1] & ~trigSync[2];
   assign abortRise = abortSync[1] & ~abortSync[2];
   assign asleep    = sleepSync[1];

   // ==========================================================
   // register file, written only by serial words
   // write-only: a host that needs the values keeps its own copy
   logic [FREQ_W-1:0]  startFrequency;
   logic [STEP_W-1:0]  stepValue;
   logic               stepNegative;
   logic [COUNT_W-1:0] stepCount;
   logic [DWELL_W-1:0] dwellInterval;
   logic               dwellUnitClk;
   logic [1:0]         multSel;
   logic               stepSourceExt;
   logic               controlWrite;

   logic [FREQ_W-1:0]  next_startFrequency;
   logic [STEP_W-1:0]  next_stepValue;
   logic               next_stepNegative;
   logic [COUNT_W-1:0] next_stepCount;
   logic [DWELL_W-1:0] next_dwellInterval;
   logic               next_dwellUnitClk;
   logic [1:0]         next_multSel;
   logic               next_stepSourceExt;

   // words are decoded by their top nibble; dwell needs only two bits
   always_comb begin
      next_startFrequency = startFrequency;
      next_stepValue      = stepValue;
      next_stepNegative   = stepNegative;
      next_stepCount      = stepCount;
      next_dwellInterval  = dwellInterval;
      next_dwellUnitClk   = dwellUnitClk;
      next_multSel        = multSel;
      next_stepSourceExt  = stepSourceExt;
      controlWrite        = 1'b0;
      if (bus.wordValid) begin
         if (bus.word[WORD_W-1 -: 2] == OP_DWELL) begin
            next_dwellUnitClk  = bus.word[DWELL_UNIT_BIT];
            next_multSel       = bus.word[MULT_LSB +: 2];
            next_dwellInterval = bus.word[DWELL_W-1:0];
         end else begin
            case (bus.word[WORD_W-1 -: 4])
               OP_CONTROL: begin
                  next_stepSourceExt = bus.word[STEP_SOURCE_BIT];
                  controlWrite       = 1'b1;
               end
               OP_STEP_COUNT: begin
                  next_stepCount = bus.word[COUNT_W-1:0];
               end
               OP_STEP_LOW: begin
                  next_stepValue[LOW_PART_W-1:0] = bus.word[LOW_PART_W-1:0];
               end
               OP_STEP_HIGH: begin
                  next_stepValue[STEP_W-1:LOW_PART_W] = bus.word[STEP_HIGH_W-1:0];
                  next_stepNegative                   = bus.word[DIRECTION_BIT];
               end
               OP_START_LOW: begin
                  next_startFrequency[LOW_PART_W-1:0] = bus.word[LOW_PART_W-1:0];
               end
               OP_START_HIGH: begin
                  next_startFrequency[FREQ_W-1:LOW_PART_W] = bus.word[LOW_PART_W-1:0];
               end
               default: begin
                  next_stepCount = stepCount;   // unmapped word: ignored
               end
            endcase
         end
      end
   end

   // reset values let a scan run before any word arrives
   always_ff @(posedge clk) begin
      if (reset) begin
         startFrequency <= START_RESET;
         stepValue      <= STEP_RESET;
         stepNegative   <= 1'b0;
         stepCount      <= COUNT_RESET;
         dwellInterval  <= DWELL_RESET;
         dwellUnitClk   <= 1'b0;
         multSel        <= MULT_SEL_RESET;
         stepSourceExt  <= 1'b0;
      end else begin
         startFrequency <= next_startFrequency;
         stepValue      <= next_stepValue;
         stepNegative   <= next_stepNegative;
         stepCount      <= next_stepCount;
         dwellInterval  <= next_dwellInterval;
         dwellUnitClk   <= next_dwellUnitClk;
         multSel        <= next_multSel;
         stepSourceExt  <= next_stepSourceExt;
      end
   end

   // ==========================================================
   // scan state machine and phase accumulator
   // the accumulator keeps running in HOLD, so the last tone goes on
   scan_state_t        state;
   scan_state_t        next_state;
   logic [COUNT_W-1:0] stepsDone;
   logic [COUNT_W-1:0] next_stepsDone;
   logic [FREQ_W-1:0]  phase;
   logic [FREQ_W-1:0]  next_phase;
   logic [FREQ_W-1:0]  next_frequency;
   logic [DAC_W-1:0]   next_dacCode;
   logic               next_cycleTick;
   logic               startScan;
   logic               advance;
   logic [FREQ_W:0]    phaseSum;
   logic [FREQ_W-1:0]  steppedFrequency;
   logic               timerRestart;

   always_comb begin
      // signed step: a negative step subtracts the magnitude
      steppedFrequency = stepNegative ? currentFrequency - {1'b0, stepValue}
                                      : currentFrequency + {1'b0, stepValue};
      phaseSum         = {1'b0, phase} + {1'b0, currentFrequency};
      startScan        = trigRise && (state != ST_RUN);
      // an external trigger edge counts as a step only once the scan runs
      advance          = (state == ST_RUN) &&
                         (stepSourceExt ? trigRise : bus.intervalDone);
      next_state       = state;
      next_stepsDone   = stepsDone;
      next_frequency   = currentFrequency;
      next_phase       = phase;
      next_dacCode     = dacCode;
      next_cycleTick   = 1'b0;
      timerRestart     = 1'b0;
      if (abortRise || controlWrite) begin
         // abort or control write returns the whole sequencer to idle
         // the control write is the host's reset after leaving sleep
         next_state     = ST_IDLE;
         next_stepsDone = '0;
         next_frequency = '0;
         next_phase     = '0;
         next_dacCode   = MIDSCALE;
         timerRestart   = 1'b1;
      end else if (asleep) begin
         // sleep: nothing moves, the output keeps its last code
         next_state = state;
      end else begin
         case (state)
            ST_IDLE: begin
               next_dacCode = MIDSCALE;
               if (startScan) begin
                  next_state     = ST_RUN;
                  next_stepsDone = '0;
                  next_frequency = startFrequency;
                  next_phase     = '0;
                  timerRestart   = 1'b1;
               end
            end
            ST_RUN: begin
               next_phase     = phaseSum[FREQ_W-1:0];
               next_cycleTick = phaseSum[FREQ_W];
               next_dacCode   = phase[FREQ_W-1 -: DAC_W];
               // one step per dwell end or per trigger edge, never both
               if (advance) begin
                  next_frequency = steppedFrequency;
                  next_stepsDone = stepsDone + 1'b1;
                  // the count-th step ends the run: HOLD keeps the last frequency with no further dwell
                  if (stepsDone + 1'b1 == stepCount) begin
                     next_state = ST_HOLD;
                  end
               end
            end
            ST_HOLD: begin
               next_phase     = phaseSum[FREQ_W-1:0];
               next_cycleTick = phaseSum[FREQ_W];
               next_dacCode   = phase[FREQ_W-1 -: DAC_W];
               if (startScan) begin
                  next_state     = ST_RUN;
                  next_stepsDone = '0;
                  next_frequency = startFrequency;
                  next_phase     = '0;
                  timerRestart   = 1'b1;
               end
            end
            default: begin
               next_state   = ST_IDLE;
               next_dacCode = MIDSCALE;
            end
         endcase
      end
   end

   // status flags follow next_state, so they change on the same edge
   // as the frequency word they describe
   always_ff @(posedge clk) begin
      if (reset) begin
         state            <= ST_IDLE;
         stepsDone        <= '0;
         phase            <= '0;
         currentFrequency <= '0;
         dacCode          <= MIDSCALE;
         bus.cycleTick    <= 1'b0;
         scanActive       <= 1'b0;
         scanDone         <= 1'b0;
      end else begin
         state            <= next_state;
         stepsDone        <= next_stepsDone;
         phase            <= next_phase;
         currentFrequency <= next_frequency;
         dacCode          <= next_dacCode;
         bus.cycleTick    <= next_cycleTick;
         scanActive       <= (next_state == ST_RUN);
         scanDone         <= (next_state == ST_HOLD);
      end
   end

   // ==========================================================
   // timer controls; sleep freezes its counters too
   // held outside RUN so a count run up in IDLE or HOLD cannot cut the first
   // dwell short; every start restarts it as well
   assign bus.timerRestart = timerRestart;
   assign bus.timerHold    = asleep || (state != ST_RUN);
   assign bus.dwellUnitClk = dwellUnitClk;
   assign bus.multSel      = multSel;
   assign bus.dwellCount   = dwellInterval;

endmodule

/* hdl/scan_if.sv */
// carrier between the sequencer, its serial receiver and its dwell timer
`timescale 1ns/1ps
interface scan_if;
   import freq_scan_pkg::*;

   logic [WORD_W-1:0]  word;          // received serial word
   logic               wordValid;     // one-cycle pulse with word
   logic               timerRestart;  // clears the dwell timer
   logic               timerHold;     // freezes the dwell timer
   logic               dwellUnitClk;  // 1 counts clocks, 0 output cycles
   logic [1:0]         multSel;       // base-interval multiplier select
   logic [DWELL_W-1:0] dwellCount;    // base intervals per frequency
   logic               cycleTick;     // one pulse per output cycle
   logic               intervalDone;  // one pulse per elapsed dwell

   modport rx    (output word, output wordValid);
   modport seq   (input word, input wordValid, output timerRestart, output timerHold, output dwellUnitClk,
                  output multSel, output dwellCount, output cycleTick, input intervalDone);
   modport timer (input timerRestart, input timerHold, input dwellUnitClk, input multSel, input dwellCount,
                  input cycleTick, output intervalDone);
endinterface

/* hdl/serial_word_rx.sv */
// serial receiver that assembles framed 16-bit words, msb first
`timescale 1ns/1ps
module serial_word_rx
   import freq_scan_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic serialClk,
   input  wire logic frameSyncN,
   input  wire logic serialData,
   scan_if.rx        bus
);

   // ==========================================================
   // pin synchronisers
   logic [1:0] sclkSync;
   logic [1:0] fsyncSync;
   logic [1:0] dataSync;
   logic       sclkLast;

   always_ff @(posedge clk) begin
      if (reset) begin
         sclkSync  <= 2'h0;
         fsyncSync <= 2'h3;
         dataSync  <= 2'h0;
         sclkLast  <= 1'b0;
      end else begin
         sclkSync  <= {sclkSync[0], serialClk};
         fsyncSync <= {fsyncSync[0], frameSyncN};
         dataSync  <= {dataSync[0], serialData};
         sclkLast  <= sclkSync[1];
      end
   end

   // ==========================================================
   // shifter: data taken on the falling serial clock inside a frame
   logic [WORD_W-1:0]   shiftReg;
   logic [BITCNT_W-1:0] bitCount;
   logic [WORD_W-1:0]   next_shiftReg;
   logic [BITCNT_W-1:0] next_bitCount;
   logic [WORD_W-1:0]   next_word;
   logic                next_wordValid;
   logic                fallEdge;

   always_comb begin
      fallEdge       = sclkLast & ~sclkSync[1];
      next_shiftReg  = shiftReg;
      next_bitCount  = bitCount;
      next_word      = bus.word;
      next_wordValid = 1'b0;
      if (fsyncSync[1]) begin
         next_bitCount = '0;                // frame ended: partial word dropped
      end else if (fallEdge) begin
         next_shiftReg = {shiftReg[WORD_W-2:0], dataSync[1]};
         if (bitCount == BITCNT_W'(WORD_W - 1)) begin
            next_word      = {shiftReg[WORD_W-2:0], dataSync[1]};
            next_wordValid = 1'b1;
            next_bitCount  = '0;
         end else begin
            next_bitCount = bitCount + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shiftReg      <= '0;
         bitCount      <= '0;
         bus.word      <= '0;
         bus.wordValid <= 1'b0;
      end else begin
         shiftReg      <= next_shiftReg;
         bitCount      <= next_bitCount;
         bus.word      <= next_word;
         bus.wordValid <= next_wordValid;
      end
   end

endmodule

/* tb/frequency_scan_sequencer_props.sv */
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/1ps
module frequency_scan_sequencer_props
   import freq_scan_pkg::*;
(
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              serialClk,
   input wire logic              frameSyncN,
   input wire logic              serialData,
   input wire logic              scanTrigger,
   input wire logic              abortScan,
   input wire logic              sleep,
   input wire logic [DAC_W-1:0]  dacCode,
   input wire logic [FREQ_W-1:0] currentFrequency,
   input wire logic              scanActive,
   input wire logic              scanDone
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ==========================================================
   // helper: cycles of sleep held high, saturating so it stays small
   logic [2:0] sleepCnt;
   logic [2:0] next_sleepCnt;
   always_comb begin
      next_sleepCnt = sleep ? ((sleepCnt == 3'h7) ? sleepCnt : sleepCnt + 3'h1) : 3'h0;
   end
   always_ff @(posedge clk) begin
      sleepCnt <= reset ? 3'h0 : next_sleepCnt;
   end

   // ==========================================================
   // properties
   chk_reset_values: assert property ($fell(reset) |-> dacCode == MIDSCALE && currentFrequency == 24'h000000
      && !scanActive && !scanDone) else $error("outputs not at reset values");
   chk_state_excl: assert property (!(scanActive && scanDone)) else $error("active and done together");
   chk_abort_idle: assert property ($rose(abortScan) && !sleep |-> ##[2:6] (!scanActive && !scanDone
      && dacCode == MIDSCALE)) else $error("abort did not return to midscale");
   chk_idle_mid: assert property (!scanActive && !scanDone && !$past(scanActive) && !$past(scanActive, 2)
      && !$past(scanDone) |-> dacCode == MIDSCALE) else $error("idle output not midscale");
   chk_trig_start: assert property ($rose(scanTrigger) && !scanActive && !sleep && !abortScan
      |-> ##[3:5] scanActive) else $error("trigger did not start scan");
   chk_done_hold: assert property (scanDone && $past(scanDone) |-> $stable(currentFrequency))
      else $error("held frequency moved");
   chk_sleep_freeze: assert property (sleepCnt >= 3'h6 |-> $stable(currentFrequency) && $stable(dacCode)
      && $stable(scanActive)) else $error("state moved in sleep");
   chk_step_in_run: assert property ($changed(currentFrequency) |-> scanActive || $past(scanActive)
      || $past(scanDone)) else $error("frequency moved outside a scan");
endmodule
bind frequency_scan_sequencer frequency_scan_sequencer_props u_props (.clk(clk), .reset(reset),
   .serialClk(serialClk), .frameSyncN(frameSyncN), .serialData(serialData), .scanTrigger(scanTrigger),
   .abortScan(abortScan), .sleep(sleep), .dacCode(dacCode), .currentFrequency(currentFrequency),
   .scanActive(scanActive), .scanDone(scanDone));

/* tb/frequency_scan_sequencer_tb_top.sv */
// self-checking bench for the frequency-scan sequencer
`timescale 1ns/1ps
module frequency_scan_sequencer_tb_top;
   import freq_scan_pkg::*;
   logic clk, reset, serialClk, frameSyncN, serialData, scanTrigger, abortScan, sleep, scanActive, scanDone;
   logic [DAC_W-1:0]  dacCode;
   logic [FREQ_W-1:0] currentFrequency, lastF, hf, hd;
   logic [23:0]       expF[$];
   int                expG[$];
   int                numErrors, nCompared, cyc, lastT, m;
   logic [MULT_W-1:0] mv;

   // ==========================================================
   // design and host
   frequency_scan_sequencer DUT (.clk(clk), .reset(reset), .serialClk(serialClk), .frameSyncN(frameSyncN),
      .serialData(serialData), .scanTrigger(scanTrigger), .abortScan(abortScan), .sleep(sleep),
      .dacCode(dacCode), .currentFrequency(currentFrequency), .scanActive(scanActive), .scanDone(scanDone));
   host_serial_model host (.clk(clk), .serialClk(serialClk), .frameSyncN(frameSyncN), .serialData(serialData));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic testDone();
      if (numErrors == 0 && nCompared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
      nCompared++;
      if (e !== s) begin
         numErrors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse();
      scanTrigger = 1'b1;
      tick(4);
      scanTrigger = 1'b0;
      tick(6);
   endtask

   // ==========================================================
   // program, note every frequency expected, trigger, and only when wt is set wait for hold
   task automatic runScan(input logic [15:0] dw, input logic neg, input logic ext, input int cnt, input int gap,
                          input logic wt);
      logic [23:0] st, f;
      logic [22:0] sp;
      int          n;
      st = {2'b10, 22'($urandom)};
      sp = {3'b000, 20'($urandom)};
      host.send({4'hC, st[11:0]});
      host.send({4'hD, st[23:12]});
      host.send({4'h2, sp[11:0]});
      host.send({4'h3, neg, sp[22:12]});
      host.send({4'h1, 12'(cnt)});
      host.send(dw);
      host.send({10'h000, ext, 5'h00});
      for (int k = 0; k <= (wt ? cnt : 0); k++) begin
         f = neg ? st - 24'(k * sp) : st + 24'(k * sp);
         expF.push_back(f);
         expG.push_back((k >= 1) ? gap : 0);
      end
      pulse();
      if (!wt) return;
      if (ext) repeat (cnt) pulse();
      for (n = 0; n < 20000 && scanDone !== 1'b1; n++) tick(1);
      if (n == 20000) begin
         numErrors++;
         testDone();
      end
      tick(20);
      check("stepsLeft", 24'h000000, 24'(expF.size()));
      check("holdFreq", f, currentFrequency);
   endtask

   // ==========================================================
   // watcher: each new frequency takes the oldest note
   always @(posedge clk) begin
      cyc++;
      if (!reset && (scanActive || scanDone) && currentFrequency !== lastF) begin
         if (expF.size() == 0) check("extraStep", 24'h000000, currentFrequency);
         else begin
            check("frequency", expF.pop_front(), currentFrequency);
            if (expG[0] != 0) check("dwellGap", 24'(expG[0]), 24'(cyc - lastT));
            void'(expG.pop_front());
         end
         lastT = cyc;
      end
      lastF = currentFrequency;
   end

   // ==========================================================
   // main sequence
   initial begin
      reset = 1'b1;
      scanTrigger = 1'b0;
      abortScan = 1'b0;
      sleep = 1'b0;
      numErrors = 0;
      nCompared = 0;
      cyc = 0;
      lastT = 0;
      void'($urandom(32'h89B0));
      tick(3);
      reset = 1'b0;
      tick(2);
      check("resetDac", 24'(MIDSCALE), 24'(dacCode));
      for (m = 0; m < 4; m++) begin
         mv = (m == 0) ? MULT_X1 : (m == 1) ? MULT_X5 : (m == 2) ? MULT_X100 : MULT_X500;
         runScan({3'b011, 2'(m), 11'h002}, m[0], 1'b0, 2, 2 * mv, 1'b1);
      end
      runScan(16'h6005, 1'b0, 1'b0, 3, 5, 1'b1);
      runScan(16'h4802, 1'b1, 1'b0, 2, 0, 1'b1);
      runScan(16'h6002, 1'b0, 1'b1, 3, 0, 1'b1);
      // abort mid-scan on a very long dwell
      runScan(16'h7FFF, 1'b0, 1'b0, 3, 0, 1'b0);
      tick(20);
      abortScan = 1'b1;
      tick(8);
      abortScan = 1'b0;
      check("abortFreq", 24'h000000, currentFrequency);
      check("abortDac", 24'(MIDSCALE), 24'(dacCode));
      // sleep freezes the running scan, then abort restores a known state
      runScan(16'h7FFF, 1'b0, 1'b0, 3, 0, 1'b0);
      tick(20);
      sleep = 1'b1;
      tick(10);
      hf = currentFrequency;
      hd = 24'(dacCode);
      tick(30);
      check("sleepFreq", hf, currentFrequency);
      check("sleepDac", hd, 24'(dacCode));
      sleep = 1'b0;
      tick(10);
      check("resumeActive", 24'h000001, 24'(scanActive));
      abortScan = 1'b1;
      tick(8);
      abortScan = 1'b0;
      check("wakeIdle", 24'h000000, 24'(scanActive));
      testDone();
   end
endmodule

/* tb/host_serial_model.sv */
// host side of the serial pins: framed 16-bit words, msb first
`timescale 1ns/1ps
module host_serial_model (
   input  wire logic clk,
   output logic      serialClk,
   output logic      frameSyncN,
   output logic      serialData
);
   // ==========================================================
   // idle: clock parked high, frame released
   initial begin
      serialClk = 1'b1;
      frameSyncN = 1'b1;
      serialData = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // four clocks per serial phase keeps each phase past the synchroniser
   task automatic send(input logic [15:0] w);
      frameSyncN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serialData = w[i];
         tick(4);
         serialClk = 1'b0;
         tick(4);
         serialClk = 1'b1;
      end
      frameSyncN = 1'b1;
      serialData = ~serialData; // released line must not look valid
      tick(8);
   endtask
endmodule
